/* File: src/acmp_ctrl.sv */
// Control and status logic for two analog comparators, APB slave.
// Assumes the analog core and pads sit outside; raw results are async.
//
// Overview of operation
// RULE1: Enable bit five powers the comparator.
// RULE2: Software waits 10 us after first enable.
// RULE3: Bit four picks positive candidate A or B.
// RULE4: Bit three picks external or internal reference.
// RULE5: Output enable routes raw result to pin.
// RULE6: Bit one reads the synchronised result.
// RULE7: Result reads zero while comparator disabled.
// RULE8: Change flag sets on every result change.
// RULE9: Set change flag raises an enabled interrupt.
// RULE10: Flag cleared by writing zero or disabling.
// RULE11: Two identical comparators, two control registers.
// RULE12: Synchronised result; bits seven, six read zero.
`timescale 1ns/10ps
module acmp_ctrl #(
    parameter int SETTLE_CYCLES = acmp_pkg::SETTLE_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [acmp_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [acmp_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [acmp_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    input wire logic first_compare_raw_i,
    input wire logic second_compare_raw_i,
    output logic first_comparator_enable_o,
    output logic second_comparator_enable_o,
    output logic first_positive_input_select_o,
    output logic second_positive_input_select_o,
    output logic first_negative_input_select_o,
    output logic second_negative_input_select_o,
    output logic first_cmp_pin_o,
    output logic first_cmp_pin_oe_o,
    output logic second_cmp_pin_o,
    output logic second_cmp_pin_oe_o
);
    localparam int N = acmp_pkg::NUM_CMP;
    localparam int DW = acmp_pkg::DATA_W;
    localparam int IW = acmp_pkg::IRQ_W;
    localparam int CW = acmp_pkg::CTRL_W;
    localparam logic [CW-1:0] CR = acmp_pkg::CTRL_RESET;

    // Per-channel control state
    logic [N-1:0] en_ff;
    logic [N-1:0] psel_ff;
    logic [N-1:0] nsel_ff;
    logic [N-1:0] oe_ff;
    logic [N-1:0] route_ff;

    // Interrupt state
    logic [IW-1:0] irq_stat_ff;
    logic [IW-1:0] irq_mask_ff;
    logic irq_ff;

    // Bus answer state
    logic [DW-1:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // Channel results
    logic [N-1:0] result_w;
    logic [N-1:0] flag_w;
    logic [N-1:0] change_w;
    logic [N-1:0] settled_w;
    logic [N-1:0] settle_done_w;
    logic [N-1:0] ctrl_hit_w;
    logic [N-1:0] ctrl_wr_w;
    logic [N-1:0] flag_clr_w;
    logic [CW-1:0] ctrl_rd_w [N];

    wire [N-1:0] raw_w = {second_compare_raw_i, first_compare_raw_i};

    // Address decode
    wire setup_w = psel_i & ~penable_i;
    wire access_w = psel_i & penable_i & pready_ff;
    wire wr_w = access_w & pwrite_i & pstrb_i[0];
    wire rd_w = access_w & ~pwrite_i;
    assign ctrl_hit_w[0] = paddr_i == acmp_pkg::CTRL1_ADDR; // see RULE11
    assign ctrl_hit_w[1] = paddr_i == acmp_pkg::CTRL2_ADDR; // see RULE11
    wire stat_hit_w = paddr_i == acmp_pkg::IRQ_STAT_ADDR;
    wire mask_hit_w = paddr_i == acmp_pkg::IRQ_MASK_ADDR;
    wire settle_hit_w = paddr_i == acmp_pkg::SETTLE_ADDR;
    wire mapped_w = |ctrl_hit_w | stat_hit_w | mask_hit_w | settle_hit_w;
    assign ctrl_wr_w = {N{wr_w}} & ctrl_hit_w;
    wire mask_wr_w = wr_w & mask_hit_w;
    // Status is cleared only for bits that were actually returned
    wire stat_rd_w = rd_w & stat_hit_w;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cmp
            // Writing zero to the flag bit clears it
            assign flag_clr_w[g] =
                ctrl_wr_w[g] & ~pwdata_i[acmp_pkg::FLAG_BIT]; // see RULE10

            // Upper reserved bits read as zero
            always_comb begin
                ctrl_rd_w[g] = CR;
                ctrl_rd_w[g][acmp_pkg::EN_BIT] = en_ff[g];
                ctrl_rd_w[g][acmp_pkg::PSEL_BIT] = psel_ff[g];
                ctrl_rd_w[g][acmp_pkg::NSEL_BIT] = nsel_ff[g];
                ctrl_rd_w[g][acmp_pkg::OE_BIT] = oe_ff[g];
                ctrl_rd_w[g][acmp_pkg::RES_BIT] = result_w[g]; // see RULE6
                ctrl_rd_w[g][acmp_pkg::FLAG_BIT] = flag_w[g];
            end // see RULE12

            acmp_channel #(
                .SETTLE_CYCLES(SETTLE_CYCLES)
            ) u_chan (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .raw_i(raw_w[g]),
                .enable_i(en_ff[g]),
                .flag_clr_i(flag_clr_w[g]),
                .result_o(result_w[g]),
                .flag_o(flag_w[g]),
                .change_o(change_w[g]),
                .settled_o(settled_w[g]),
                .settle_done_o(settle_done_w[g])
            );

            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    en_ff[g] <= CR[acmp_pkg::EN_BIT];
                    psel_ff[g] <= CR[acmp_pkg::PSEL_BIT];
                    nsel_ff[g] <= CR[acmp_pkg::NSEL_BIT];
                    oe_ff[g] <= CR[acmp_pkg::OE_BIT];
                end else if (ctrl_wr_w[g]) begin
                    en_ff[g] <= pwdata_i[acmp_pkg::EN_BIT]; // see RULE1
                    psel_ff[g] <= pwdata_i[acmp_pkg::PSEL_BIT]; // see RULE3
                    nsel_ff[g] <= pwdata_i[acmp_pkg::NSEL_BIT]; // see RULE4
                    oe_ff[g] <= pwdata_i[acmp_pkg::OE_BIT];
                end
            end

            // Pin routed only while enabled and output enabled
            always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    route_ff[g] <= 1'b0;
                end else begin
                    route_ff[g] <= en_ff[g] & oe_ff[g]; // see RULE5
                end
            end
        end
    endgenerate

    // Events: result change while enabled, and settle time elapsed
    wire [IW-1:0] irq_evt_w = {settle_done_w, change_w}; // see RULE9
    wire [IW-1:0] irq_clr_w =
        stat_rd_w ? prdata_ff[IW-1:0] : {IW{1'b0}};
    // Set wins over the read clear
    wire [IW-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr_w) | irq_evt_w;
    wire [IW-1:0] nxt_irq_mask =
        mask_wr_w ? pwdata_i[IW-1:0] : irq_mask_ff;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= acmp_pkg::IRQ_MASK_RESET;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask); // see RULE9
        end
    end

    // Read data is captured in setup; one-cycle access phase follows
    logic [DW-1:0] rd_mux_w;
    always_comb begin
        rd_mux_w = '0;
        if (ctrl_hit_w[0]) begin
            rd_mux_w[CW-1:0] = ctrl_rd_w[0];
        end else if (ctrl_hit_w[1]) begin
            rd_mux_w[CW-1:0] = ctrl_rd_w[1];
        end else if (stat_hit_w) begin
            rd_mux_w[IW-1:0] = irq_stat_ff;
        end else if (mask_hit_w) begin
            rd_mux_w[IW-1:0] = irq_mask_ff;
        end else if (settle_hit_w) begin
            rd_mux_w[N-1:0] = settled_w;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= (setup_w && !pwrite_i) ? rd_mux_w : '0;
            pready_ff <= setup_w;
            pslverr_ff <= setup_w & ~mapped_w;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign irq_o = irq_ff;
    assign first_comparator_enable_o = en_ff[0];
    assign second_comparator_enable_o = en_ff[1];
    assign first_positive_input_select_o = psel_ff[0];
    assign second_positive_input_select_o = psel_ff[1];
    assign first_negative_input_select_o = nsel_ff[0];
    assign second_negative_input_select_o = nsel_ff[1];
    // Raw path stays unsynchronised on purpose; pin follows the analog edge
    assign first_cmp_pin_o = first_compare_raw_i & route_ff[0]; // see RULE5
    assign second_cmp_pin_o = second_compare_raw_i & route_ff[1];
    assign first_cmp_pin_oe_o = route_ff[0];
    assign second_cmp_pin_oe_o = route_ff[1];
endmodule : acmp_ctrl

/* File: shared/acmp_pkg.sv */
// Constants shared by the dual comparator control block.
// Assumes a 200 MHz system clock and a 12-bit APB byte address.
package acmp_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_CMP = 2;

    // Register indices; the byte address is four times the index
    localparam logic [9:0] CTRL1_IDX = 10'h0AC;
    localparam logic [9:0] CTRL2_IDX = 10'h0AD;
    localparam logic [9:0] IRQ_STAT_IDX = 10'h0B0;
    localparam logic [9:0] IRQ_MASK_IDX = 10'h0B1;
    localparam logic [9:0] SETTLE_IDX = 10'h0B2;
    localparam logic [ADDR_W-1:0] CTRL1_ADDR = {CTRL1_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] CTRL2_ADDR = {CTRL2_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] SETTLE_ADDR = {SETTLE_IDX, 2'b00};

    // Control register field positions
    localparam int EN_BIT = 5;
    localparam int PSEL_BIT = 4;
    localparam int NSEL_BIT = 3;
    localparam int OE_BIT = 2;
    localparam int RES_BIT = 1;
    localparam int FLAG_BIT = 0;
    localparam int CTRL_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

    // Interrupt status and mask layout
    localparam int IRQ_W = 4;
    localparam int IRQ_CHG_LSB = 0;
    localparam int IRQ_SETTLE_LSB = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    // Settling time after the first enable
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_US = 10;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    localparam int SETTLE_CNT_W = 12;
endpackage : acmp_pkg

/* File: src/acmp_channel.sv */
// One comparator channel: result synchroniser, change flag, settle timer.
// Assumes raw_i is asynchronous to clk_sys_i; enable_i is on clk_sys_i.
`timescale 1ns/10ps
module acmp_channel #(
    parameter int SETTLE_CYCLES = acmp_pkg::SETTLE_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic raw_i,
    input wire logic enable_i,
    input wire logic flag_clr_i,
    output logic result_o,
    output logic flag_o,
    output logic change_o,
    output logic settled_o,
    output logic settle_done_o
);
    localparam int CW = acmp_pkg::SETTLE_CNT_W;
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic result_ff;
    logic flag_ff;
    logic started_ff;
    logic settled_ff;
    logic [CW-1:0] cnt_ff;

    // A sample counts only once the two later stages agree
    wire sync_stable = sync2_ff == sync3_ff;
    wire nxt_result = enable_i & (sync_stable ? sync3_ff : result_ff);
    // Forced drop on disable is not a comparator event
    wire change_w = enable_i & (nxt_result != result_ff);
    // Hardware set wins over a software clear in the same cycle
    wire nxt_flag = enable_i & (change_w | (flag_ff & ~flag_clr_i));
    wire counting = (started_ff | enable_i) & ~settled_ff;
    wire cnt_last = counting & (cnt_ff == LAST);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= raw_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_ff <= 1'b0;
            flag_ff <= 1'b0;
        end else begin
            result_ff <= nxt_result; // see RULE6 see RULE7 see RULE12
            flag_ff <= nxt_flag; // see RULE8 see RULE10
        end
    end

    // Timer runs once, from the first enable, even if disabled meanwhile
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            started_ff <= 1'b0;
            settled_ff <= 1'b0;
            cnt_ff <= '0;
        end else begin
            started_ff <= started_ff | enable_i;
            settled_ff <= settled_ff | cnt_last; // see RULE2
            if (counting && !cnt_last) begin
                cnt_ff <= cnt_ff + CW'(1);
            end
        end
    end

    assign result_o = result_ff;
    assign flag_o = flag_ff;
    assign change_o = change_w;
    assign settled_o = settled_ff;
    assign settle_done_o = cnt_last;
endmodule : acmp_channel

/* File: bench/acmp_ctrl_asserts.sv */
// Port checker for the dual comparator control block.
// Assumes one clock domain and a bench that runs real APB traffic.
`timescale 1ns/10ps
module acmp_ctrl_asserts #(
    parameter int SETTLE_CYCLES = acmp_pkg::SETTLE_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [acmp_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [acmp_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [acmp_pkg::DATA_W-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o,
    input wire logic first_compare_raw_i,
    input wire logic second_compare_raw_i,
    input wire logic first_comparator_enable_o,
    input wire logic second_comparator_enable_o,
    input wire logic first_positive_input_select_o,
    input wire logic second_positive_input_select_o,
    input wire logic first_negative_input_select_o,
    input wire logic second_negative_input_select_o,
    input wire logic first_cmp_pin_o,
    input wire logic first_cmp_pin_oe_o,
    input wire logic second_cmp_pin_o,
    input wire logic second_cmp_pin_oe_o
);
    wire logic acc = psel_i && penable_i && pready_o;
    wire logic hit1 = paddr_i == acmp_pkg::CTRL1_ADDR;
    wire logic hit2 = paddr_i == acmp_pkg::CTRL2_ADDR;
    wire logic hit_irq = paddr_i == acmp_pkg::IRQ_STAT_ADDR
        || paddr_i == acmp_pkg::IRQ_MASK_ADDR;
    wire logic mapped = hit1 || hit2 || hit_irq
        || paddr_i == acmp_pkg::SETTLE_ADDR;
    wire logic wr1 = acc && pwrite_i && pstrb_i[0] && hit1;
    wire logic wr2 = acc && pwrite_i && pstrb_i[0] && hit2;
    wire logic rd1 = acc && !pwrite_i && hit1;
    wire logic rdc = acc && !pwrite_i && (hit1 || hit2);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_pready_next: assert property (psel_i && !penable_i |=> pready_o)
        else $error("pready missing after setup");
    a_error_unmapped: assert property (acc |-> pslverr_o == !mapped)
        else $error("pslverr wrong for address");
    a_enable_write: assert property (wr1 |=> first_comparator_enable_o
        == $past(pwdata_i[acmp_pkg::EN_BIT])) else $error("enable not written");
    a_possel_write: assert property (wr2 |=> second_positive_input_select_o
        == $past(pwdata_i[acmp_pkg::PSEL_BIT])) else $error("select not written");
    a_pin_raw: assert property (first_cmp_pin_o |-> first_compare_raw_i)
        else $error("pin driven without raw result");
    a_pin_oe_off: assert property (!second_comparator_enable_o
        |=> !second_cmp_pin_oe_o) else $error("pin enabled while off");
    a_ctrl_reserved: assert property (rdc |-> prdata_o[31:6] == 26'h0)
        else $error("reserved bits not zero");
    a_result_off: assert property (rd1 && !first_comparator_enable_o
        && !$past(first_comparator_enable_o) |-> prdata_o[1:0] == 2'h0)
        else $error("result or flag set while off");
endmodule : acmp_ctrl_asserts

bind acmp_ctrl acmp_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (.*);

/* File: bench/acmp_core_model.sv */
// Behavioural analog comparator core for the bench.
// Assumes input levels are plain codes that the bench sets.
`timescale 1ns/10ps
module acmp_core_model (
    input wire logic enable_i,
    input wire logic pos_sel_i,
    input wire logic neg_sel_i,
    input wire logic [7:0] cand_a_i,
    input wire logic [7:0] cand_b_i,
    input wire logic [7:0] ext_ref_i,
    input wire logic [7:0] int_ref_i,
    output logic raw_o
);
    wire logic [7:0] pos = pos_sel_i ? cand_b_i : cand_a_i;
    wire logic [7:0] neg = neg_sel_i ? int_ref_i : ext_ref_i;
    // Powered down core holds its output low
    assign raw_o = enable_i && (pos > neg);
endmodule : acmp_core_model

/* File: bench/testbench.sv */
// Directed APB bench for the dual comparator control block.
// Assumes the core model and checker are compiled before it.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
    localparam logic [11:0] C1 = acmp_pkg::CTRL1_ADDR;
    localparam logic [11:0] C2 = acmp_pkg::CTRL2_ADDR;
    localparam logic [11:0] ST = acmp_pkg::IRQ_STAT_ADDR;
    localparam logic [11:0] MK = acmp_pkg::IRQ_MASK_ADDR;
    logic clk_sys_i, rst_n_i, psel, penable, pwrite, err, pready, pslverr;
    logic irq, raw1, raw2, en1, en2, ps1, ps2, ns1, ns2, pin1, oe1, pin2, oe2;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdata, prdata;
    logic [7:0] a1, b1, a2, b2, ext_ref, int_ref;
    int n_mismatch = 0;
    int n_checks = 0;
    acmp_ctrl #(.SETTLE_CYCLES(8)) i_acmp_ctrl (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
        .first_compare_raw_i(raw1), .second_compare_raw_i(raw2),
        .first_comparator_enable_o(en1), .second_comparator_enable_o(en2),
        .first_positive_input_select_o(ps1),
        .second_positive_input_select_o(ps2),
        .first_negative_input_select_o(ns1),
        .second_negative_input_select_o(ns2),
        .first_cmp_pin_o(pin1), .first_cmp_pin_oe_o(oe1),
        .second_cmp_pin_o(pin2), .second_cmp_pin_oe_o(oe2));
    acmp_core_model i_acmp_core_model_a (.enable_i(en1), .pos_sel_i(ps1),
        .neg_sel_i(ns1), .cand_a_i(a1), .cand_b_i(b1), .ext_ref_i(ext_ref),
        .int_ref_i(int_ref), .raw_o(raw1));
    acmp_core_model i_acmp_core_model_b (.enable_i(en2), .pos_sel_i(ps2),
        .neg_sel_i(ns2), .cand_a_i(a2), .cand_b_i(b2), .ext_ref_i(ext_ref),
        .int_ref_i(int_ref), .raw_o(raw2));
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        // Look mid-cycle, so the next rising edge is the sampling edge
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rdata = prdata;
        err = pslverr;
        @(posedge clk_sys_i);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
            input string nm);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, rdata)
    endtask : rd
    task automatic summarize();
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // Whole sequence is about a hundred cycles; generous margin
    initial begin
        #20000;
        n_mismatch++;
        summarize();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rst_n_i} = '0;
        {a1, b1, a2, b2} = {8'h0a, 8'h0a, 8'h0a, 8'h3c};
        {ext_ref, int_ref} = {8'h05, 8'h32};
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(C1, 32'h0, "ctrl1 reset");
        rd(C2, 32'h0, "ctrl2 reset");
        rd(MK, 32'h0, "mask reset");
        rd(12'h000, 32'h0, "unmapped");
        `CHK("unmapped err", 1'b1, err)
        xfer(1'b1, MK, 32'h1);
        xfer(1'b1, C1, 32'hff);
        rd(C1, 32'h3c, "ctrl1 on");
        `CHK("enable out", 1'b1, en1)
        b1 <= 8'h40;
        repeat (12) @(posedge clk_sys_i);
        rd(C1, 32'h3f, "ctrl1 rise");
        `CHK("pin and oe", 2'h3, {pin1, oe1})
        `CHK("irq set", 1'b1, irq)
        rd(ST, 32'h5, "status");
        rd(ST, 32'h0, "status clr");
        `CHK("irq clr", 1'b0, irq)
        xfer(1'b1, C1, 32'h2d);
        repeat (6) @(posedge clk_sys_i);
        rd(C1, 32'h2d, "cand a");
        xfer(1'b1, C1, 32'h24);
        repeat (6) @(posedge clk_sys_i);
        rd(C1, 32'h27, "ext ref");
        xfer(1'b1, C1, 32'h24);
        rd(C1, 32'h26, "flag clr");
        xfer(1'b1, C1, 32'h04);
        rd(C1, 32'h04, "ctrl1 off");
        `CHK("pin off", 2'h0, {pin1, oe1})
        xfer(1'b1, C2, 32'h38);
        repeat (6) @(posedge clk_sys_i);
        rd(C2, 32'h3b, "ctrl2");
        `CHK("ctrl2 outs", 3'h7, {en2, ps2, ns2})
        rd(C1, 32'h04, "ctrl1 kept");
        rd(acmp_pkg::SETTLE_ADDR, 32'h3, "settled");
        summarize();
    end
endmodule : testbench
